// ---- logic/offset_regs_cfg.svh ----
// Register map constants for the display buffer offset register bank
//
// Summary of operation
// - Frame start register holds a 22-bit byte offset of the displayed frame.
// - Frame start offset may be rewritten while the display is running.
// - Frame address bits 21:4 apply only at the next frame scan start.
// - Frame pixel offset bits 3:0 apply immediately on write.
// - Compressed start register holds a 22-bit compressed buffer byte offset.
`ifndef OFFSET_REGS_CFG_SVH
`define OFFSET_REGS_CFG_SVH

// -----------------------------------------------------------------------
// Offsets and fields
// -----------------------------------------------------------------------
`define FRAME_BUFFER_START_OFS      16'h8310
`define COMPRESSED_BUFFER_START_OFS 16'h8314
`define OFFSET_FIELD_W             22
`define PIXEL_FIELD_W              4
`define OFFSET_RESET               22'h000000

`endif

// ---- logic/offset_regs_pkg.sv ----
// Types shared by the display buffer offset register bank
package offset_regs_pkg;

  typedef logic [21:0] offset_field_t;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } bus_state_t;

endpackage : offset_regs_pkg

// ---- logic/offset_word_reg.sv ----
// Single 22-bit storage word with register read data
`timescale 1ns/1ps
module offset_word_reg #(
  parameter int WIDTH = 22
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] rd_data
);

  // Storage; reset value chosen since the hardware leaves it undefined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end

endmodule : offset_word_reg

// ---- logic/display_buffer_offset_regs.sv ----
// APB register bank for frame and compressed display buffer offsets
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "offset_regs_cfg.svh"
module display_buffer_offset_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          frame_start,
  output offset_regs_pkg::offset_field_t     active_frame_offset,
  output offset_regs_pkg::offset_field_t     compressed_start_field,
  output logic                               frame_offset_pending
);
  import offset_regs_pkg::*;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    bus_state_t    bus;
    logic [31:0]   rdata;
    logic          err;
    logic [17:0]   frame_addr;   // Bits 21:4 presently used by scan-out
    logic          pending;
    logic [2:0]    fs_sync;      // [0] first flop, [1] second, [2] delay
  } bank_state_t;

  bank_state_t st_q;
  bank_state_t st_d;

  offset_field_t frame_start_field;
  offset_field_t comp_q;
  logic          wr_frame;
  logic          wr_comp;
  logic          frame_edge;
  logic          access;

  // Address match for a full-word register
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [15:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  // Pad a 22-bit field to a bus word; reserved bits read zero
  function automatic logic [31:0] to_word(input offset_field_t f);
    to_word = {10'h000, f};
  endfunction : to_word

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  // Writes land in the access phase only; partial strobes still store the
  // whole word so the field never holds a half-updated offset.
  assign access   = psel && penable;
  assign wr_frame = access && pwrite &&
                    hit(paddr, `FRAME_BUFFER_START_OFS);
  assign wr_comp  = access && pwrite &&
                    hit(paddr, `COMPRESSED_BUFFER_START_OFS);

  // Register storage; the frame word may be written at any time
  offset_word_reg #(.WIDTH(`OFFSET_FIELD_W)) u_frame (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_frame),
    .wr_data (pwdata[21:0]),
    .rd_data (frame_start_field)
  );

  offset_word_reg #(.WIDTH(`OFFSET_FIELD_W)) u_comp (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_comp),
    .wr_data (pwdata[21:0]),
    .rd_data (comp_q)
  );

  // -----------------------------------------------------------------------
  // Frame start synchroniser
  // -----------------------------------------------------------------------
  // The pin comes from the display timing domain, so it passes two flops
  // before any logic reads it; a third copy of the synchronised level lets
  // a rising edge be seen exactly once. The reset level matches the idle
  // low pin, so no false frame start follows reset.
  assign frame_edge = st_q.fs_sync[1] && !st_q.fs_sync[2];

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Shift the frame-start pin through the synchroniser
    st_d.fs_sync = {st_q.fs_sync[1:0], frame_start};
    case (st_q.bus)
      BUS_IDLE: begin
        if (psel && !penable) begin
          st_d.bus = BUS_ACCESS;
        end
      end
      BUS_ACCESS: begin
        st_d.bus = BUS_IDLE;
      end
      default: begin
        st_d.bus = BUS_IDLE;
      end
    endcase
    // Read data captured at setup so it is stable by the access edge
    if (psel && !penable) begin
      st_d.err = 1'b0;
      if (hit(paddr, `FRAME_BUFFER_START_OFS)) begin
        st_d.rdata = to_word(frame_start_field);
      end else if (hit(paddr, `COMPRESSED_BUFFER_START_OFS)) begin
        st_d.rdata = to_word(comp_q);
      end else begin
        st_d.rdata = 32'h00000000;
        st_d.err   = 1'b1;
      end
    end
    // Address part waits for the next frame start
    if (wr_frame) begin
      st_d.pending = 1'b1;
    end
    if (frame_edge) begin
      st_d.frame_addr = wr_frame ? pwdata[21:4]
                                 : frame_start_field[21:4];
      st_d.pending    = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{bus: BUS_IDLE, rdata: 32'h00000000, err: 1'b0,
                frame_addr: 18'h00000, pending: 1'b0, fs_sync: 3'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // Zero wait states: the slave answers in the first access cycle
  assign pready  = 1'b1;
  assign prdata  = st_q.rdata;
  assign pslverr = access && st_q.err;
  // Pixel bits bypass the frame-start hold and act at once
  assign active_frame_offset = {st_q.frame_addr,
                                frame_start_field[3:0]};
  assign compressed_start_field = comp_q;
  assign frame_offset_pending   = st_q.pending;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  // Every check runs on the bank clock and stays quiet while reset is held,
  // when the stored offsets are forced to their zero reset value.
  AST_FRAME_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_frame |=> frame_start_field == $past(pwdata[21:0]))
    else $error("frame offset not stored");
  AST_COMP_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_comp |=> comp_q == $past(pwdata[21:0]))
    else $error("compressed offset not stored");
  AST_PIXEL_NOW: assert property (@(posedge pclk) disable iff (!presetn)
    wr_frame |=> active_frame_offset[3:0] == $past(pwdata[3:0]))
    else $error("pixel offset not immediate");
  AST_ADDR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !frame_edge |=> $stable(active_frame_offset[21:4]))
    else $error("address changed mid frame");
  AST_ADDR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    frame_edge && !wr_frame |=>
      active_frame_offset[21:4] == $past(frame_start_field[21:4]))
    else $error("address not loaded at frame start");
  AST_PENDING: assert property (@(posedge pclk) disable iff (!presetn)
    wr_frame && !frame_edge |=> frame_offset_pending)
    else $error("pending flag not raised");
  AST_READ_BACK: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && hit(paddr, `COMPRESSED_BUFFER_START_OFS)
      |=> prdata == to_word($past(comp_q)))
    else $error("read data mismatch");
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:22] == 10'h000)
    else $error("reserved bits not zero");

  AST_BUS_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> st_q.bus == BUS_ACCESS)
    else $error("access phase without a setup cycle");
  AST_PEND_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    frame_edge |=> !frame_offset_pending)
    else $error("pending flag not cleared at frame start");
  AST_FRAME_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_frame |=> $stable(frame_start_field))
    else $error("frame offset changed without a write");
  AST_COMP_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_comp |=> $stable(comp_q))
    else $error("compressed offset changed without a write");
  AST_EDGE_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    frame_edge |=> !frame_edge)
    else $error("frame start seen twice");

  // Scenarios worth seeing in a run

  COV_FRAME_WR: cover property (@(posedge pclk) disable iff (!presetn)
    wr_frame ##[1:50] frame_edge);
  COV_COMP_WR: cover property (@(posedge pclk) disable iff (!presetn)
    wr_comp);
  COV_BAD_ADDR: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);
  COV_LOAD_PENDING: cover property (@(posedge pclk) disable iff (!presetn)
    frame_edge && frame_offset_pending);
  COV_READ: cover property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && !pslverr);

endmodule : display_buffer_offset_regs

// ---- bench/tb_top.sv ----
// Self-checking bench for the display buffer offset register bank
`timescale 1ns/1ps
`include "offset_regs_cfg.svh"
module tb_top;
  import offset_regs_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [15:0]   paddr;
  logic [31:0]   pwdata;
  logic [3:0]    pstrb;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          frame_start;
  offset_field_t active_frame_offset;
  offset_field_t compressed_start_field;
  logic          frame_offset_pending;
  logic [31:0]   rd;
  logic          er;
  int            errors;
  int            total_checks;

  display_buffer_offset_regs #(.ADDR_W(16)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .active_frame_offset(active_frame_offset),
    .compressed_start_field(compressed_start_field),
    .frame_offset_pending(frame_offset_pending));

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Compare one value, widened to a full word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      end_sim();
    end
  endtask : apb

  // Frame scan start pulse, then bounded wait for the pending flag to drop
  task automatic frame_pulse;
    int n;
    @(posedge pclk);
    frame_start <= 1'b1;
    repeat (3) @(posedge pclk);
    frame_start <= 1'b0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (frame_offset_pending !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++;
      end_sim();
    end
  endtask : frame_pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    apb(1'b0, `FRAME_BUFFER_START_OFS, 32'h0);
    chk(rd, 32'h0, "frame reset");
    apb(1'b0, `COMPRESSED_BUFFER_START_OFS, 32'h0);
    chk(rd, 32'h0, "compressed reset");
    chk({10'h0, active_frame_offset}, 32'h0, "frame out reset");
    chk({10'h0, compressed_start_field}, 32'h0, "cmp out reset");
    chk({31'h0, frame_offset_pending}, 32'h0, "pending reset");
    $display("test_reset done");
  endtask : test_reset

  // Address bits wait for frame start, pixel bits land at once
  task automatic test_frame_pan;
    apb(1'b1, `FRAME_BUFFER_START_OFS, 32'h0012_345A);
    @(negedge pclk);
    chk({10'h0, active_frame_offset}, 32'h0000_000A, "pixel now");
    chk({31'h0, frame_offset_pending}, 32'h1, "pending");
    frame_pulse();
    chk({10'h0, active_frame_offset}, 32'h0012_345A, "addr at frame");
    apb(1'b1, `FRAME_BUFFER_START_OFS, 32'h003F_FFF3);
    @(negedge pclk);
    chk({10'h0, active_frame_offset}, 32'h0012_3453, "pan mid");
    apb(1'b0, `FRAME_BUFFER_START_OFS, 32'h0);
    chk(rd, 32'h003F_FFF3, "frame readback");
    frame_pulse();
    chk({10'h0, active_frame_offset}, 32'h003F_FFF3, "pan done");
    $display("test_frame_pan done");
  endtask : test_frame_pan

  task automatic test_compressed;
    apb(1'b1, `COMPRESSED_BUFFER_START_OFS, 32'h002A_BCD0);
    @(negedge pclk);
    chk({10'h0, compressed_start_field}, 32'h002A_BCD0, "cmp out");
    apb(1'b0, `COMPRESSED_BUFFER_START_OFS, 32'h0);
    chk(rd, 32'h002A_BCD0, "cmp readback");
    $display("test_compressed done");
  endtask : test_compressed

  // Unmapped write is refused and leaves the frame register alone
  task automatic test_unmapped;
    apb(1'b1, 16'h831C, 32'h0000_1111);
    chk({31'h0, er}, 32'h1, "unmapped err");
    apb(1'b0, `FRAME_BUFFER_START_OFS, 32'h0);
    chk(rd, 32'h003F_FFF3, "frame kept");
    chk({31'h0, er}, 32'h0, "mapped ok");
    $display("test_unmapped done");
  endtask : test_unmapped

  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 16'h0;
    pwdata       = 32'h0;
    pstrb        = 4'hF;
    frame_start  = 1'b0;
    errors       = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_frame_pan();
    test_compressed();
    test_unmapped();
    end_sim();
  end
endmodule : tb_top
